// File: adc_seq_map.svh
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_STATUS_CTRL 3'h0
`define OFS_CONV_CTRL   3'h1
`define OFS_PIN_EN      3'h2
`define OFS_RES_HIGH    3'h3
`define OFS_RES_LOW     3'h4
`define OFS_SEQ_STATE   3'h5

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SC_DONE_BIT     7
`define SC_IRQEN_BIT    6
`define SC_CHAN_MSB     3
`define CC_PU_BIT       7
`define CC_PRESC_MSB    3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SC_RESET        8'h00
`define CC_RESET        8'h00
`define PE_RESET        8'h00

// ----------------------------------------
// Channel codes for reference conversions
// ----------------------------------------
`define CHAN_REF_LOW    4'h8
`define CHAN_REF_HIGH   4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define BUS_CLK_HZ      50000000
`define CONV_CLK_MAX_HZ 2000000
`define HALF_MIN_CYCLES ((`BUS_CLK_HZ + 2 * `CONV_CLK_MAX_HZ - 1) / (2 * `CONV_CLK_MAX_HZ))
`define SAMPLE_TICKS    14
`define SAR_BITS        10

`endif

// File: adc_seq_pkg.sv
`include "adc_seq_map.svh"

package adc_seq_pkg;

  // Mode control states, Gray along idle-sample-convert-store
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b11,
    ST_STORE   = 2'b10
  } seq_state_t;

  typedef logic [`SAR_BITS-1:0] sar_word_t;

endpackage

// File: adc_seq_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// RQ1: Status-control write starts a new conversion
// RQ2: Control register write aborts, never starts
// RQ3: Pin-enable write aborts, never starts
// RQ4: Status-control write mid-conversion restarts afresh
// RQ5: Start arms sampler and SAR together
// RQ6: Sample window end launches SAR conversion
// RQ7: SAR end-of-conversion finishes the conversion
// RQ8: Reference conversions skip the sampler entirely
// RQ9: Channel chosen; result copied on completion
// RQ10: Result register written and read independently
// RQ11: Sampler and SAR never run together
// RQ12: Sampler clock gated unless sampling
// RQ13: Sample window is fourteen conversion clocks
// RQ14: Prescaled conversion clock, at most 2 MHz
// RQ15: Exactly one of eight channels routed
// RQ16: Done flag set; interrupt while flag enabled
// RQ17: Status-control write clears done flag
// RQ18: Result register read clears done flag
// RQ19: Power-down aborts, stops clock, registers live
// RQ20: Result and done flag update together

`include "adc_seq_map.svh"

module adc_seq_top
  import adc_seq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ce,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_cmp,
  output logic      [2:0] o_chan_sel,
  output logic      [7:0] o_chan_en,
  output logic            o_sh_clk_en,
  output logic            o_ref_load,
  output logic            o_ref_high,
  output logic      [9:0] o_dac_code,
  output logic            o_conv_clk,
  output logic            o_busy,
  output logic            o_done_irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  seq_state_t state_q;
  logic       irq_en_q;
  logic [3:0] chan_q;
  logic       pu_q;
  logic [3:0] presc_q;
  logic [7:0] pin_en_q;
  logic       done_q;
  sar_word_t  result_q;
  logic [3:0] sh_cnt_q;
  logic [4:0] div_q;
  logic       conv_clk_q;
  logic       cmp_meta_q;
  logic       cmp_sync_q;
  logic       sc_wr;
  logic       cc_wr;
  logic       pe_wr;
  logic       res_rd;
  logic       start_req;
  logic       abort_req;
  logic       clk_edge;
  logic       tick;
  logic       win_last;
  logic       sampling;
  logic       sar_arm;
  logic       sar_go;
  logic       sar_abort;
  logic       sar_busy;
  logic       sar_eoc;
  sar_word_t  sar_result;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Codes 8 and up convert a reference instead of a pin
  function automatic logic is_ref(input logic [3:0] chan);
    return chan[3];
  endfunction

  // Half period of the conversion clock, floored at the 2 MHz limit
  function automatic logic [4:0] half_len(input logic [3:0] presc);
    logic [4:0] req;
    req = {1'b0, presc} + 5'h1;
    return (req < 5'(`HALF_MIN_CYCLES)) ? 5'(`HALF_MIN_CYCLES) : req;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign sc_wr  = i_wr && (i_addr == `OFS_STATUS_CTRL);
  assign cc_wr  = i_wr && (i_addr == `OFS_CONV_CTRL);
  assign pe_wr  = i_wr && (i_addr == `OFS_PIN_EN);
  assign res_rd = i_rd && ((i_addr == `OFS_RES_HIGH) || (i_addr == `OFS_RES_LOW));

  // Start only while powered up; any restart also aborts the SAR
  // RQ1: start on write
  assign start_req = sc_wr && pu_q;
  // RQ2: control write aborts
  // RQ3: pin write aborts
  // RQ19: power-down aborts
  assign abort_req = cc_wr || pe_wr || !pu_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Registers stay writable in power-down
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_en_q <= 1'(`SC_RESET >> `SC_IRQEN_BIT);
      chan_q   <= 4'(`SC_RESET);
      pu_q     <= 1'(`CC_RESET >> `CC_PU_BIT);
      presc_q  <= 4'(`CC_RESET);
      pin_en_q <= `PE_RESET;
    end else if (i_ce) begin
      if (sc_wr) begin
        irq_en_q <= i_wdata[`SC_IRQEN_BIT];
        chan_q   <= i_wdata[`SC_CHAN_MSB:0];
      end
      if (cc_wr) begin
        pu_q    <= i_wdata[`CC_PU_BIT];
        presc_q <= i_wdata[`CC_PRESC_MSB:0];
      end
      if (pe_wr) begin
        pin_en_q <= i_wdata;
      end
    end
  end

  // ----------------------------------------
  // Conversion clock prescaler
  // ----------------------------------------
  // RQ14: clamped prescaler
  assign clk_edge = pu_q && (div_q == half_len(presc_q) - 5'h1);
  assign tick     = clk_edge && !conv_clk_q;

  // Restarted on each start so the window aligns to whole clocks
  // RQ19: clock stopped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_q      <= 5'h0;
      conv_clk_q <= 1'b0;
    end else if (i_ce) begin
      if (!pu_q || start_req || cc_wr) begin
        div_q      <= 5'h0;
        conv_clk_q <= 1'b0;
      end else if (clk_edge) begin
        div_q      <= 5'h0;
        conv_clk_q <= !conv_clk_q;
      end else begin
        div_q <= div_q + 5'h1;
      end
    end
  end

  // ----------------------------------------
  // Comparator synchroniser
  // ----------------------------------------
  // Comparator is analog, so it is treated as asynchronous
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else if (i_ce) begin
      cmp_meta_q <= i_cmp;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ----------------------------------------
  // Sample and hold window
  // ----------------------------------------
  assign sampling = (state_q == ST_SAMPLE);
  // RQ13: fourteenth tick ends window
  assign win_last = sampling && tick && (sh_cnt_q == 4'(`SAMPLE_TICKS - 1));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sh_cnt_q <= 4'h0;
    end else if (i_ce) begin
      if (start_req) begin
        sh_cnt_q <= 4'h0;
      end else if (sampling && tick) begin
        sh_cnt_q <= sh_cnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // Hand-off to the SAR machine
  // ----------------------------------------
  // RQ5: arm both machines
  assign sar_arm   = start_req;
  // RQ4: discard running conversion
  assign sar_abort = abort_req || start_req;
  // RQ6: window end starts SAR
  // RQ8: reference skips sampler
  assign sar_go    = (win_last && !abort_req && !sc_wr) ||
                     (start_req && is_ref(i_wdata[`SC_CHAN_MSB:0]));

  sar_engine u_sar (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_abort   (sar_abort),
    .i_arm     (sar_arm),
    .i_go      (sar_go),
    .i_tick    (tick),
    .i_cmp     (cmp_sync_q),
    .o_dac     (o_dac_code),
    .o_result  (sar_result),
    .o_busy    (sar_busy),
    .o_eoc     (sar_eoc)
  );

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  // A fresh start outranks every abort source
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      if (start_req) begin
        // RQ4: restart from scratch
        state_q <= is_ref(i_wdata[`SC_CHAN_MSB:0]) ? ST_CONVERT : ST_SAMPLE;
      end else if (abort_req) begin
        state_q <= ST_IDLE;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            state_q <= ST_IDLE;
          end
          ST_SAMPLE: begin
            // RQ11: strict alternation
            if (win_last) begin
              state_q <= ST_CONVERT;
            end
          end
          ST_CONVERT: begin
            // RQ7: end of conversion
            if (sar_eoc) begin
              state_q <= ST_STORE;
            end
          end
          ST_STORE: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Result register and done flag
  // ----------------------------------------
  // RQ9: copy SAR result
  // RQ10: write port of result
  // RQ20: same-cycle update
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      result_q <= '0;
    end else if (i_ce && (state_q == ST_STORE)) begin
      result_q <= sar_result;
    end
  end

  // Set wins over a clear landing in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      done_q <= 1'b0;
    end else if (i_ce) begin
      if (state_q == ST_STORE) begin
        // RQ16: set on completion
        done_q <= 1'b1;
      end else if (sc_wr || res_rd) begin
        // RQ17: cleared by write
        // RQ18: cleared by result read
        done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // RQ10: bus read port
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `OFS_STATUS_CTRL: o_rdata <= {done_q, irq_en_q, 2'b00, chan_q};
          `OFS_CONV_CTRL:   o_rdata <= {pu_q, 3'b000, presc_q};
          `OFS_PIN_EN:      o_rdata <= pin_en_q;
          `OFS_RES_HIGH:    o_rdata <= {6'h00, result_q[`SAR_BITS-1:8]};
          `OFS_RES_LOW:     o_rdata <= result_q[7:0];
          `OFS_SEQ_STATE:   o_rdata <= {o_busy, sar_busy, sampling, 3'b000, state_q};
          default:          o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Analog side outputs
  // ----------------------------------------
  assign o_chan_sel  = chan_q[2:0];
  // RQ15: one-hot channel switch
  assign o_chan_en   = sampling ? (8'h01 << chan_q[2:0]) : 8'h00;
  // RQ12: sampler clock gate
  assign o_sh_clk_en = sampling;
  assign o_ref_load  = (state_q == ST_CONVERT) && is_ref(chan_q);
  assign o_ref_high  = (chan_q == `CHAN_REF_HIGH);
  assign o_conv_clk  = conv_clk_q;
  assign o_busy      = (state_q != ST_IDLE);
  // RQ16: pending while flag set
  assign o_done_irq  = done_q && irq_en_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  start_on_write_a: assert property ( // RQ1
    i_ce && sc_wr && pu_q |=> o_busy && (sh_cnt_q == 4'h0) &&
                              (!done_q || $past(state_q == ST_STORE)))
    else $error("status-control write did not start a conversion");

  ctrl_write_abort_a: assert property ( // RQ2
    i_ce && cc_wr |=> !o_busy && !sar_busy ##1 (!o_busy || $past(start_req)))
    else $error("control write did not abort");

  pin_write_abort_a: assert property ( // RQ3
    i_ce && pe_wr |=> !o_busy && !sar_busy)
    else $error("pin-enable write did not abort");

  arm_on_start_a: assert property ( // RQ5
    i_ce && start_req && !is_ref(i_wdata[3:0]) |=> o_sh_clk_en && u_sar.armed_q && !sar_busy)
    else $error("start did not arm the SAR");

  window_handoff_a: assert property ( // RQ6
    i_ce && win_last && !i_wr |=> (state_q == ST_CONVERT) && sar_busy)
    else $error("sample window end did not launch the SAR");

  ref_bypass_a: assert property ( // RQ8
    i_ce && start_req && is_ref(i_wdata[3:0]) |=> (state_q == ST_CONVERT) && sar_busy && !o_sh_clk_en)
    else $error("reference conversion used the sampler");

  store_result_a: assert property ( // RQ20
    i_ce && (state_q == ST_STORE) |=> done_q && (result_q == $past(sar_result)))
    else $error("result and done flag not updated together");

  never_overlap_a: assert property ( // RQ11
    !(o_sh_clk_en && sar_busy))
    else $error("sampler and SAR active together");

  flag_clear_a: assert property ( // RQ18
    i_ce && (sc_wr || res_rd) && (state_q != ST_STORE) |=> !done_q && !o_done_irq)
    else $error("done flag not cleared");

  power_down_a: assert property ( // RQ19
    i_ce && !pu_q |=> !o_busy && !sar_busy && !o_conv_clk)
    else $error("power-down left the converter running");

  window_len_a: assert property ( // RQ13
    i_ce && sampling && tick && (sh_cnt_q != 4'hd) && !i_wr |=> sampling)
    else $error("sample window ended early");

  channel_cov_c: cover property (i_ce && sc_wr && pu_q && !is_ref(i_wdata[3:0]) ##[1:1000] done_q);
  reference_cov_c: cover property (i_ce && start_req && is_ref(i_wdata[3:0]) ##[1:600] done_q);
  restart_cov_c: cover property (i_ce && sar_busy && start_req);
  abort_cov_c: cover property (i_ce && sampling && pe_wr);

endmodule

// File: sar_engine.sv
`timescale 1ns/1ns

module sar_engine
  import adc_seq_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_sys_rst,
  input  wire logic      i_ce,
  input  wire logic      i_abort,
  input  wire logic      i_arm,
  input  wire logic      i_go,
  input  wire logic      i_tick,
  input  wire logic      i_cmp,
  output sar_word_t      o_dac,
  output sar_word_t      o_result,
  output logic           o_busy,
  output logic           o_eoc
);

  logic       armed_q;
  logic [3:0] idx_q;

  // ----------------------------------------
  // Bit decision
  // ----------------------------------------
  // Keep or drop the bit under trial, then raise the next one
  function automatic sar_word_t resolve(input sar_word_t dac, input logic [3:0] idx,
                                        input logic keep);
    sar_word_t w;
    w = dac;
    w[idx] = keep;
    if (idx != 4'h0) begin
      w[idx - 4'h1] = 1'b1;
    end
    return w;
  endfunction

  // ----------------------------------------
  // Successive approximation
  // ----------------------------------------
  // Abort first, so a restart that arms in the same cycle still wins
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      armed_q  <= 1'b0;
      o_busy   <= 1'b0;
      o_eoc    <= 1'b0;
      o_dac    <= '0;
      o_result <= '0;
      idx_q    <= 4'h0;
    end else if (i_ce) begin
      o_eoc <= 1'b0;
      if (i_abort) begin
        armed_q <= 1'b0;
        o_busy  <= 1'b0;
        o_dac   <= '0;
      end
      if (i_arm) begin
        armed_q <= 1'b1;
      end
      if (i_go && (armed_q || i_arm)) begin
        armed_q <= 1'b0;
        o_busy  <= 1'b1;
        o_dac   <= {1'b1, {(`SAR_BITS-1){1'b0}}};
        idx_q   <= 4'(`SAR_BITS - 1);
      end else if (o_busy && i_tick && !i_abort) begin
        o_dac <= resolve(o_dac, idx_q, i_cmp);
        if (idx_q == 4'h0) begin
          o_busy   <= 1'b0;
          o_eoc    <= 1'b1;
          o_result <= resolve(o_dac, idx_q, i_cmp);
        end else begin
          idx_q <= idx_q - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  eoc_needs_run_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RQ7
    $rose(o_eoc) |-> $past(o_busy) && !o_busy)
    else $error("end of conversion without a running conversion");

endmodule

// File: test_sar_adc_conversion_sequencer.sv
`timescale 1ns/1ns
`include "adc_seq_map.svh"

module test_sar_adc_conversion_sequencer
  import adc_seq_pkg::*;
();
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       i_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_ce = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_cmp = 1'b0;
  logic [7:0] o_rdata;
  logic [2:0] o_chan_sel;
  logic [7:0] o_chan_en;
  logic       o_sh_clk_en;
  logic       o_ref_load;
  logic       o_ref_high;
  logic [9:0] o_dac_code;
  logic       o_conv_clk;
  logic       o_busy;
  logic       o_done_irq;
  int         err_count = 0;
  int         checked = 0;
  int         half_cnt = 100;
  int         n_hi = 0;
  logic       clk_prev = 1'b0;
  logic       rd_d = 1'b0;
  logic [15:0] seed = 16'h0018;
  sar_word_t  target = '0;
  logic [7:0] exp_q[$];
  string      name_q[$];

  always #10 i_clk = ~i_clk;

  adc_seq_top u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp(i_cmp),
    .o_chan_sel(o_chan_sel), .o_chan_en(o_chan_en), .o_sh_clk_en(o_sh_clk_en),
    .o_ref_load(o_ref_load), .o_ref_high(o_ref_high), .o_dac_code(o_dac_code),
    .o_conv_clk(o_conv_clk), .o_busy(o_busy), .o_done_irq(o_done_irq)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Expected read data goes to the queue; the monitor compares it
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    name_q.push_back(n);
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask

  // Comparator stand-in: keeps a trial bit while target is not below it
  always @(posedge i_clk) i_cmp <= (target >= o_dac_code);

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) check("read queue", 16'h1, 16'h0);
      else check(name_q.pop_front(), o_rdata, exp_q.pop_front());
    end
    rd_d <= i_rd & i_ce;
    if (o_conv_clk !== clk_prev) begin
      if (half_cnt < 13) check("conv clk half period", 16'h1, 16'h0);
      half_cnt <= (i_wr || i_sys_rst) ? 100 : 1;
    end else begin
      half_cnt <= (i_wr || i_sys_rst) ? 100 : half_cnt + 1; // Writes may restart the prescaler
    end
    clk_prev <= o_conv_clk;
  end

  // ----------------------------------------
  // Conversion tasks
  // ----------------------------------------
  task automatic start_conv(input logic [3:0] ch);
    int n;
    seed = lfsr_step(seed);
    target = seed[9:0];
    wr(`OFS_STATUS_CTRL, {4'h4, ch});
    #1;
    check("busy after start", o_busy, 1'b1);
    if (ch < 4'h8) begin
      check("chan sel", o_chan_sel, ch[2:0]);
      check("chan enable", o_chan_en, 8'h01 << ch[2:0]);
      check("sampler clock on", o_sh_clk_en, 1'b1);
      n = 0;
      while (o_sh_clk_en === 1'b1 && n < 1000) begin
        @(posedge i_clk);
        #1;
        n++;
      end
      check("sample window", (n >= 349 && n <= 352), 1'b1);
      check("convert after sample", o_busy, 1'b1);
      check("sampler gated in convert", o_sh_clk_en, 1'b0);
    end else begin
      repeat (2) @(posedge i_clk);
      #1;
      check("ref load", o_ref_load, 1'b1);
      check("ref high", o_ref_high, ch == 4'h9);
      check("ref skips sampler", o_sh_clk_en, 1'b0);
      check("ref no channel", o_chan_en, 8'h00);
    end
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (o_done_irq !== 1'b1 && n < 1000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check("done irq", o_done_irq, 1'b1);
    check("idle at done", o_busy, 1'b0);
  endtask

  task automatic read_res(input logic [3:0] ch);
    rd(`OFS_STATUS_CTRL, {4'hc, ch}, "status after done");
    rd(`OFS_RES_HIGH, {6'h00, target[9:8]}, "result high");
    #1;
    check("done cleared by read", o_done_irq, 1'b0);
    rd(`OFS_RES_LOW, target[7:0], "result low");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(`OFS_STATUS_CTRL, 8'h00, "status reset");
    rd(`OFS_CONV_CTRL, 8'h00, "control reset");
    rd(`OFS_PIN_EN, 8'h00, "pin enable reset");
    rd(3'h6, 8'h00, "unmapped read");
    check("idle after reset", {o_busy, o_conv_clk, o_done_irq}, 3'b000);
    $display("test reset done");

    wr(`OFS_STATUS_CTRL, 8'h42);
    repeat (60) @(posedge i_clk);
    check("no start powered down", {o_busy, o_conv_clk}, 2'b00);
    rd(`OFS_STATUS_CTRL, 8'h42, "status live in power down");
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(`OFS_CONV_CTRL, 8'h80);
    i_ce <= 1'b1;
    rd(`OFS_CONV_CTRL, 8'h00, "write ignored without ce");
    $display("test power down done");

    wr(`OFS_CONV_CTRL, 8'h80);
    for (int c = 0; c < 8; c++) begin
      start_conv(c[3:0]);
      wait_done();
      read_res(c[3:0]);
    end
    $display("test channels done");

    for (int k = 0; k < 4; k++) begin
      if (k < 2) begin
        wr(`OFS_STATUS_CTRL, 8'h45);
      end else begin
        start_conv(4'h5);
      end
      repeat (50 * k) @(posedge i_clk);
      wr(k[0] ? `OFS_PIN_EN : `OFS_CONV_CTRL, k[0] ? 8'h5a : 8'h80);
      #1;
      check("abort stops", o_busy, 1'b0);
      repeat (800) @(posedge i_clk);
      check("abort no restart", {o_busy, o_done_irq}, 2'b00);
    end
    rd(`OFS_PIN_EN, 8'h5a, "pin enable stored");
    start_conv(4'h6);
    wr(`OFS_CONV_CTRL, 8'h00);
    #1;
    check("power down aborts", o_busy, 1'b0);
    repeat (60) @(posedge i_clk);
    check("conv clk stopped", o_conv_clk, 1'b0);
    // Slow prescaler setting: half period of sixteen bus clocks
    wr(`OFS_CONV_CTRL, 8'h8f);
    rd(`OFS_CONV_CTRL, 8'h8f, "prescaler stored");
    @(posedge o_conv_clk);
    n_hi = 0;
    while (o_conv_clk === 1'b1 && n_hi < 100) begin
      @(posedge i_clk);
      #1;
      n_hi++;
    end
    check("slow half period", n_hi, 16'h10);
    wr(`OFS_CONV_CTRL, 8'h80);
    $display("test abort done");

    start_conv(4'h1);
    repeat (100) @(posedge i_clk);
    start_conv(4'h3);
    wait_done();
    start_conv(4'h2);
    check("done cleared by start", o_done_irq, 1'b0);
    wait_done();
    read_res(4'h2);
    $display("test restart done");

    for (int r = 8; r < 10; r++) begin
      start_conv(r[3:0]);
      wait_done();
      read_res(r[3:0]);
    end
    $display("test reference done");
    repeat (4) @(posedge i_clk);
    report_and_stop();
  end

  // Watchdog sized well past the expected run of about 12000 cycles
  initial begin
    #(20 * 60000);
    err_count++;
    report_and_stop();
  end
endmodule
